// >>> rtl/pcsd_pkg.sv
package pcsd_pkg;
   localparam int NUM_PORTS = 4;
   localparam int ADDR_W = 8;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_MODE = 8'h04;
   localparam logic [7:0] OFS_PORTCFG = 8'h08;
   localparam logic [7:0] OFS_ADVERT = 8'h0c;
   localparam logic [7:0] OFS_STRAPS = 8'h10;
   // Bit positions inside the per-port management images
   localparam int BIT_SPEED = 13;
   localparam int BIT_ANEN = 12;
   localparam int BIT_RESTART = 9;
   localparam int BIT_LINKTEST = 8;
   localparam int BIT_FIBER = 2;
   // Control register fields
   localparam int BIT_CTRL_ANEN = 0;
   // Straps register field positions
   localparam int STRAP_SPEED = 0;
   localparam int STRAP_LINK = 1;
   localparam int STRAP_MEDIA = 2;
   localparam int STRAP_FD = 3;
   localparam int NUM_STRAPS = 4;
   // Advertised ability vector positions
   localparam int ADV_10HD = 0;
   localparam int ADV_10FD = 1;
   localparam int ADV_100HD = 2;
   localparam int ADV_100FD = 3;
   // Reset values
   localparam logic RST_ANEN = 1'b1;
   localparam logic [3:0] RST_ADVERT = 4'hf;
   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Bus state machines
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_RESP = 2'b10
   } pcsd_bus_t;
endpackage

// >>> rtl/pcsd_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser for asynchronous strap pins
module pcsd_sync #(
   parameter int W = 4
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic [W-1:0] async,
   output logic [W-1:0] synced
);
   logic [W-1:0] stage1;
   logic [W-1:0] next_stage1;
   logic [W-1:0] next_synced;

   // Stage one feeds stage two only
   always_comb begin
      next_stage1 = async;
      next_synced = stage1;
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         stage1 <= '0;
         synced <= '0;
      end else begin
         stage1 <= next_stage1;
         synced <= next_synced;
      end
   end
endmodule

// >>> rtl/pcsd_strap_decode.sv
// Our own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module pcsd_strap_decode (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic speedStrap,
   input wire logic linkTestStrap,
   input wire logic mediaStrap,
   input wire logic full_duplex_strap,
   output logic [3:0] speed100,
   output logic [3:0] linkTestOff,
   output logic [3:0] fiberSelect,
   output logic [3:0] scramblerBypass,
   output logic [3:0] anRestart,
   output logic [3:0] anEnable,
   output logic [15:0] advertise,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready
);
   localparam int NP = pcsd_pkg::NUM_PORTS;
   localparam int NS = pcsd_pkg::NUM_STRAPS;

   // Strap pins as gathered, and after the synchroniser
   logic [NS-1:0] strapPins;
   logic [NS-1:0] strapLevel;

   // Decoded configuration state, shared by every port
   logic speedPrev;
   logic anEn;
   logic spd;
   logic lto;
   logic fib;
   logic restartFlag;
   logic [3:0] adv;
   logic next_speedPrev;
   logic next_anEn;
   logic next_spd;
   logic next_lto;
   logic next_fib;
   logic next_restartFlag;
   logic [3:0] next_adv;
   logic speedRise;

   // Register bus state
   pcsd_pkg::pcsd_bus_t wrState;
   pcsd_pkg::pcsd_bus_t next_wrState;
   pcsd_pkg::pcsd_bus_t rdState;
   pcsd_pkg::pcsd_bus_t next_rdState;
   logic awHave;
   logic next_awHave;
   logic wHave;
   logic next_wHave;
   logic [7:0] awAddrQ;
   logic [7:0] next_awAddrQ;
   logic [31:0] wDataQ;
   logic [31:0] next_wDataQ;
   logic [3:0] wStrbQ;
   logic [3:0] next_wStrbQ;
   logic [1:0] next_bresp;
   logic [1:0] next_rresp;
   logic [31:0] next_rdata;
   logic [7:0] wrAddr;
   logic [31:0] wrData;
   logic [3:0] wrStrb;
   logic awTake;
   logic wTake;
   logic wrTake;
   logic rdTake;
   logic ctrlWrite;

   // Offsets that answer OKAY; anything else gets SLVERR
   function automatic logic addrKnown(input logic [7:0] a);
      logic hit;
      hit = 1'b0;
      if (a == pcsd_pkg::OFS_CTRL) begin
         hit = 1'b1;
      end
      if (a == pcsd_pkg::OFS_MODE) begin
         hit = 1'b1;
      end
      if (a == pcsd_pkg::OFS_PORTCFG) begin
         hit = 1'b1;
      end
      if (a == pcsd_pkg::OFS_ADVERT) begin
         hit = 1'b1;
      end
      if (a == pcsd_pkg::OFS_STRAPS) begin
         hit = 1'b1;
      end
      return hit;
   endfunction

   // Advertised abilities from the three straps
   // Fiber carries no 10M; on copper, link strap high keeps to 10M
   function automatic logic [3:0] advFromStraps(
      input logic link,
      input logic media,
      input logic fd
   );
      logic [3:0] caps;
      logic allow10;
      logic allow100;
      allow10 = !media;
      allow100 = media | !link;
      caps = 4'h0;
      caps[pcsd_pkg::ADV_10HD] = allow10;
      caps[pcsd_pkg::ADV_10FD] = allow10 & fd;
      caps[pcsd_pkg::ADV_100HD] = allow100;
      caps[pcsd_pkg::ADV_100FD] = allow100 & fd;
      return caps;
   endfunction

   // Gather the pins by field position
   always_comb begin
      strapPins = '0;
      strapPins[pcsd_pkg::STRAP_SPEED] = speedStrap;
      strapPins[pcsd_pkg::STRAP_LINK] = linkTestStrap;
      strapPins[pcsd_pkg::STRAP_MEDIA] = mediaStrap;
      strapPins[pcsd_pkg::STRAP_FD] = full_duplex_strap;
   end

   // Pins are asynchronous to mclk: two flops first
   pcsd_sync #(
      .W(NS)
   ) u_sync (
      .mclk(mclk),
      .rstn(rstn),
      .async(strapPins),
      .synced(strapLevel)
   );

   // Strap decode; forced values hold while A/N runs
   always_comb begin
      speedRise = strapLevel[pcsd_pkg::STRAP_SPEED] && !speedPrev;
      next_speedPrev = strapLevel[pcsd_pkg::STRAP_SPEED];
      next_spd = spd;
      next_lto = lto;
      next_fib = fib;
      next_adv = adv;
      next_anEn = anEn;
      if (ctrlWrite) begin
         next_anEn = wrData[pcsd_pkg::BIT_CTRL_ANEN];
      end
      if (anEn) begin
         next_adv = advFromStraps(strapLevel[pcsd_pkg::STRAP_LINK],
            strapLevel[pcsd_pkg::STRAP_MEDIA],
            strapLevel[pcsd_pkg::STRAP_FD]);
      end else begin
         next_spd = strapLevel[pcsd_pkg::STRAP_SPEED];
         next_lto = strapLevel[pcsd_pkg::STRAP_LINK];
         next_fib = strapLevel[pcsd_pkg::STRAP_MEDIA];
      end
      // A control write with wstrb[0] set clears; a new rise in that cycle wins
      next_restartFlag = restartFlag;
      if (ctrlWrite) begin
         next_restartFlag = 1'b0;
      end
      if (anEn && speedRise) begin
         next_restartFlag = 1'b1;
      end
   end

   // Reset prev low matches the synchroniser, so no false rise
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         speedPrev <= 1'b0;
         anEn <= pcsd_pkg::RST_ANEN;
         spd <= 1'b0;
         lto <= 1'b0;
         fib <= 1'b0;
         restartFlag <= 1'b0;
         adv <= pcsd_pkg::RST_ADVERT;
      end else begin
         speedPrev <= next_speedPrev;
         anEn <= next_anEn;
         spd <= next_spd;
         lto <= next_lto;
         fib <= next_fib;
         restartFlag <= next_restartFlag;
         adv <= next_adv;
      end
   end

   // Same settings copied to every port
   assign speed100 = {NP{spd}};
   assign linkTestOff = {NP{lto}};
   assign fiberSelect = {NP{fib}};
   assign scramblerBypass = {NP{fib}};
   assign anRestart = {NP{restartFlag}};
   assign anEnable = {NP{anEn}};
   assign advertise = {NP{adv}};

   // Write channel handshakes
   assign awready = (wrState == pcsd_pkg::BUS_IDLE) && !awHave;
   assign wready = (wrState == pcsd_pkg::BUS_IDLE) && !wHave;
   assign bvalid = (wrState == pcsd_pkg::BUS_RESP);

   // Address and data taken in either order, held until both
   always_comb begin
      awTake = awvalid && awready;
      wTake = wvalid && wready;
      wrAddr = awHave ? awAddrQ : awaddr;
      wrData = wHave ? wDataQ : wdata;
      wrStrb = wHave ? wStrbQ : wstrb;
      wrTake = (awHave || awTake) && (wHave || wTake);
      ctrlWrite = wrTake && (wrAddr == pcsd_pkg::OFS_CTRL) && wrStrb[0];
      next_wrState = wrState;
      next_awHave = awHave;
      next_wHave = wHave;
      next_awAddrQ = awAddrQ;
      next_wDataQ = wDataQ;
      next_wStrbQ = wStrbQ;
      next_bresp = bresp;
      unique case (wrState)
         pcsd_pkg::BUS_IDLE: begin
            if (awTake) begin
               next_awHave = 1'b1;
               next_awAddrQ = awaddr;
            end
            if (wTake) begin
               next_wHave = 1'b1;
               next_wDataQ = wdata;
               next_wStrbQ = wstrb;
            end
            if (wrTake) begin
               next_awHave = 1'b0;
               next_wHave = 1'b0;
               next_wrState = pcsd_pkg::BUS_RESP;
               next_bresp = addrKnown(wrAddr) ? pcsd_pkg::RESP_OKAY :
                  pcsd_pkg::RESP_SLVERR;
            end
         end
         pcsd_pkg::BUS_RESP: begin
            if (bready) begin
               next_wrState = pcsd_pkg::BUS_IDLE;
            end
         end
         default: begin
            next_wrState = pcsd_pkg::BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         wrState <= pcsd_pkg::BUS_IDLE;
         awHave <= 1'b0;
         wHave <= 1'b0;
         awAddrQ <= 8'h00;
         wDataQ <= 32'h0;
         wStrbQ <= 4'h0;
         bresp <= pcsd_pkg::RESP_OKAY;
      end else begin
         wrState <= next_wrState;
         awHave <= next_awHave;
         wHave <= next_wHave;
         awAddrQ <= next_awAddrQ;
         wDataQ <= next_wDataQ;
         wStrbQ <= next_wStrbQ;
         bresp <= next_bresp;
      end
   end

   // Read channel handshakes
   assign arready = (rdState == pcsd_pkg::BUS_IDLE);
   assign rvalid = (rdState == pcsd_pkg::BUS_RESP);

   // Read data is registered, so it stands with rvalid
   always_comb begin
      rdTake = arvalid && arready;
      next_rdState = rdState;
      next_rdata = rdata;
      next_rresp = rresp;
      unique case (rdState)
         pcsd_pkg::BUS_IDLE: begin
            if (rdTake) begin
               next_rdState = pcsd_pkg::BUS_RESP;
               next_rresp = addrKnown(araddr) ? pcsd_pkg::RESP_OKAY :
                  pcsd_pkg::RESP_SLVERR;
               next_rdata = 32'h0;
               case (araddr)
                  pcsd_pkg::OFS_CTRL: begin
                     next_rdata[pcsd_pkg::BIT_CTRL_ANEN] = anEn;
                  end
                  pcsd_pkg::OFS_MODE: begin
                     next_rdata = {29'h0, fib, lto, spd};
                  end
                  pcsd_pkg::OFS_PORTCFG: begin
                     next_rdata[pcsd_pkg::BIT_SPEED] = spd;
                     next_rdata[pcsd_pkg::BIT_ANEN] = anEn;
                     next_rdata[pcsd_pkg::BIT_RESTART] = restartFlag;
                     next_rdata[pcsd_pkg::BIT_LINKTEST] = lto;
                     next_rdata[pcsd_pkg::BIT_FIBER] = fib;
                  end
                  pcsd_pkg::OFS_ADVERT: begin
                     next_rdata = {28'h0, adv};
                  end
                  pcsd_pkg::OFS_STRAPS: begin
                     next_rdata = {28'h0, strapLevel};
                  end
                  default: begin
                     next_rdata = 32'h0;
                  end
               endcase
            end
         end
         pcsd_pkg::BUS_RESP: begin
            if (rready) begin
               next_rdState = pcsd_pkg::BUS_IDLE;
            end
         end
         default: begin
            next_rdState = pcsd_pkg::BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rdState <= pcsd_pkg::BUS_IDLE;
         rdata <= 32'h0;
         rresp <= pcsd_pkg::RESP_OKAY;
      end else begin
         rdState <= next_rdState;
         rdata <= next_rdata;
         rresp <= next_rresp;
      end
   end
endmodule

// >>> tb/pcsd_checker.sv
`timescale 1ns/1ps
module pcsd_checker(
   input wire logic mclk,
   input wire logic rstn,
   input wire logic [3:0] speed100,
   input wire logic [3:0] fiberSelect,
   input wire logic [3:0] scramblerBypass,
   input wire logic [3:0] linkTestOff,
   input wire logic [3:0] anRestart,
   input wire logic [3:0] anEnable,
   input wire logic [15:0] advertise,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic [31:0] rdata
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   chk_fiber_scr: assert property (scramblerBypass == fiberSelect)
      else $error("bypass differs from fiber");
   chk_port_same: assert property (speed100 inside {4'h0, 4'hf})
      else $error("ports disagree");
   chk_link_same: assert property (linkTestOff inside {4'h0, 4'hf})
      else $error("link test differs between ports");
   chk_restart_an: assert property ($rose(anRestart[0]) |-> anEnable[0])
      else $error("restart without auto-negotiation");
   chk_adv_hold: assert property (!anEnable[0] |=> $stable(advertise))
      else $error("advertisement moved while forced");
   chk_speed_hold: assert property (anEnable[0] |=> $stable(speed100))
      else $error("speed moved during auto-negotiation");
   chk_bvalid_hold: assert property (bvalid && !bready |=> bvalid)
      else $error("write response dropped early");
   chk_rvalid_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read response dropped early");
endmodule
bind pcsd_strap_decode pcsd_checker u_chk(.*);

// >>> tb/pcsd_board.sv
`timescale 1ns/1ps
module pcsd_board(
   input wire logic mclk,
   input wire logic [2:0] sel,
   output logic speedStrap,
   output logic linkTestStrap,
   output logic mediaStrap
);
   // Fiber never strapped without 100M
   always_ff @(posedge mclk) begin
      speedStrap <= sel[0] | sel[2];
      linkTestStrap <= sel[1];
      mediaStrap <= sel[2]; // chip-wide fallback only
   end
endmodule

// >>> tb/phy_config_strap_decode_bench.sv
`timescale 1ns/1ps
module phy_config_strap_decode_bench;
   logic mclk = 1'h0, rstn = 1'h0, full_duplex_strap = 1'h0;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
   logic arvalid = 1'h0, rready = 1'h0, awready, wready, bvalid;
   logic arready, rvalid, speedStrap, linkTestStrap, mediaStrap;
   logic [3:0] wstrb = 4'hf, anRestart, anEnable;
   logic [3:0] speed100, linkTestOff, fiberSelect, scramblerBypass;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic [15:0] advertise;
   logic [1:0] bresp, rresp;
   logic [2:0] sel = 3'h0;
   logic [31:0] rv;
   logic [1:0] rr;
   int n_errors = 0, checks_done = 0;
   pcsd_strap_decode u_dut(.*);
   pcsd_board u_brd(.*);
   initial forever #2.5 mclk = ~mclk;
   task ck(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         n_errors++;
         $display("ERROR %0t %h %h", $time, g, e);
      end
   endtask
   // Address and data may be taken on different edges
   task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         @(posedge mclk);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
      end while (!bvalid);
      r = bresp;
      bready <= 1'h0;
      @(posedge mclk);
   endtask
   // Read data taken at the edge where rvalid is seen
   task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do begin
         @(posedge mclk);
         if (arready) arvalid <= 1'h0;
      end while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'h0;
      @(posedge mclk);
   endtask
   task final_report;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge mclk);
      rstn <= 1'h1;
      @(posedge mclk);
      wr(pcsd_pkg::OFS_CTRL, 32'h0, rr);
      ck(rr, pcsd_pkg::RESP_OKAY);
      // Eight-cycle wait, four more than the sel-to-output delay
      for (int v = 0; v < 8; v++) begin
         sel <= v[2:0];
         repeat (8) @(posedge mclk);
         ck(speed100, {4{v[0] | v[2]}});
         ck(linkTestOff, {4{v[1]}});
         ck(fiberSelect, {4{v[2]}});
         ck(scramblerBypass, {4{v[2]}});
         rd(pcsd_pkg::OFS_STRAPS, rv, rr);
         ck(rv, {29'h0, v[2], v[1], v[0] | v[2]});
      end
      wr(8'h40, 32'h0, rr);
      ck(rr, pcsd_pkg::RESP_SLVERR);
      rd(8'h40, rv, rr);
      ck(rr, pcsd_pkg::RESP_SLVERR);
      wr(pcsd_pkg::OFS_CTRL, 32'h1, rr);
      rd(pcsd_pkg::OFS_CTRL, rv, rr);
      ck(rv, 32'h1);
      sel <= 3'h0;
      full_duplex_strap <= 1'h1;
      repeat (8) @(posedge mclk);
      ck(anRestart, 4'h0);
      ck(speed100, 4'hf);
      sel <= 3'h1;
      repeat (8) @(posedge mclk);
      ck(anRestart, 4'hf);
      ck(advertise, {4{advertise[3:0]}});
      rd(pcsd_pkg::OFS_PORTCFG, rv, rr);
      ck(rv[pcsd_pkg::BIT_RESTART], 1'h1);
      final_report;
   end
   initial begin
      #20000;
      n_errors++;
      final_report;
   end
endmodule
